// *** src/apcm_defs.svh ***
`ifndef APCM_DEFS_SVH
`define APCM_DEFS_SVH
`define APCM_OFS_ROLE      8'h13
`define APCM_OFS_RATE      8'h14
`define APCM_OFS_STS       8'h15
`define APCM_RST_ROLE      8'h02
`define APCM_RST_RATE      8'h48
`define APCM_RST_STS       8'hff
`define APCM_B_ROLE        7
`define APCM_B_MANUAL      6
`define APCM_B_PLL_BYP     5
`define APCM_B_GATE        4
`define APCM_B_FAMILY      3
`define APCM_F_REF         2:0
`define APCM_F_RATE        7:4
`define APCM_F_RATIO       3:0
`define APCM_CODE_INVALID  4'hf
`define APCM_RATE_CODES    9
`define APCM_RATIO_CODES   13
`define APCM_CLK_HZ        40000000
`define APCM_TOL_LO_PCT    98
`define APCM_TOL_HI_PCT    110
`define APCM_FAM441_NUM    147
`define APCM_FAM441_DEN    160
`define APCM_STALL_DIV     4000
`endif

// *** src/apcm_pkg.sv ***
package apcm_pkg;
  typedef logic [3:0] apcm_code_t;
  typedef enum logic [1:0] {
    APCM_ROOT_PLL  = 2'h0,
    APCM_ROOT_BCLK = 2'h1,
    APCM_ROOT_REF  = 2'h2
  } apcm_root_e;
endpackage

// *** src/apcm_top.sv ***
// Contract
// (RL1) Role bit 0: slave, clocks come in; 1: device drives both clocks.
// (RL2) Auto bit 0: device derives dividers and PLL; 1: custom settings supplied.
// (RL3) Under auto configuration the bypass bit turns the PLL off.
// (RL4) Master only: gate bit forces both transmitted clocks low.
// (RL5) Master: family bit picks 48 kHz (0) or 44.1 kHz (1) multiples.
// (RL6) Three-bit reference frequency code, reset 2, master with mode 0.
// (RL7) Four-bit programmed rate, codes 0..8, reset 4, rest reserved.
// (RL8) Slave under auto configuration ignores programmed rate and ratio.
// (RL9) Four-bit programmed ratio, codes 0..12 for 16..2048, reset 8.
// (RL10) Detected rate reported, same coding, 15 means invalid.
// (RL11) Detected ratio reported, same coding, 15 means invalid.
// (RL12) Monitor status resets to all ones.
// (RL13) Reference mode 0 uses the code; 1 uses a frame multiple.
// (RL14) Slave, auto, PLL off: root clock is bit clock unless reference chosen.
// (RL15) Master generates frame sync at rate, bit clock at ratio times rate.
`include "apcm_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module apcm_top #(
  parameter int CLK_HZ = `APCM_CLK_HZ,
  parameter int DEPTH  = 2
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       bclk_in,
  output logic            bclk_out,
  output logic            bclk_oe_n,
  input  wire logic       frame_sync_in,
  output logic            frame_sync_out,
  output logic            frame_sync_oe_n,
  input  wire logic       reference_frequency_mode,
  input  wire logic       slave_root_clock_source,
  input  wire logic       custom_pll_enable,
  output logic            pll_enable,
  output logic      [1:0] root_clock_select,
  output logic      [2:0] reference_frequency_code,
  output logic            reference_from_frame,
  output logic            clocks_from_pins
);
  localparam int PW = 20;

  // Base 48 kHz family rate for a code, zero when reserved
  function automatic logic [31:0] rate_hz(input apcm_pkg::apcm_code_t c);
    unique case (c)
      4'h0: rate_hz = 32'd8000;
      4'h1: rate_hz = 32'd16000;
      4'h2: rate_hz = 32'd24000;
      4'h3: rate_hz = 32'd32000;
      4'h4: rate_hz = 32'd48000;
      4'h5: rate_hz = 32'd96000;
      4'h6: rate_hz = 32'd192000;
      4'h7: rate_hz = 32'd384000;
      4'h8: rate_hz = 32'd768000;
      default: rate_hz = 32'd0;
    endcase
  endfunction

  function automatic logic [11:0] ratio_val(input apcm_pkg::apcm_code_t c);
    unique case (c)
      4'h0: ratio_val = 12'd16;
      4'h1: ratio_val = 12'd24;
      4'h2: ratio_val = 12'd32;
      4'h3: ratio_val = 12'd48;
      4'h4: ratio_val = 12'd64;
      4'h5: ratio_val = 12'd96;
      4'h6: ratio_val = 12'd128;
      4'h7: ratio_val = 12'd192;
      4'h8: ratio_val = 12'd256;
      4'h9: ratio_val = 12'd384;
      4'ha: ratio_val = 12'd512;
      4'hb: ratio_val = 12'd1024;
      4'hc: ratio_val = 12'd2048;
      default: ratio_val = 12'd0;
    endcase
  endfunction

  // Either family is accepted: the window spans 48k down to 44.1k plus margin
  function automatic apcm_pkg::apcm_code_t rate_code(input logic [PW-1:0] p);
    logic [63:0] prod;
    rate_code = `APCM_CODE_INVALID;
    for (int c = 0; c < `APCM_RATE_CODES; c++) begin
      prod = 64'(p) * 64'(rate_hz(4'(c)));
      if (prod * 64'd100 >= 64'(CLK_HZ) * 64'(`APCM_TOL_LO_PCT) &&
          prod * 64'd100 <= 64'(CLK_HZ) * 64'(`APCM_TOL_HI_PCT))
        rate_code = 4'(c);
    end
  endfunction

  function automatic apcm_pkg::apcm_code_t ratio_code(input logic [PW-1:0] n);
    ratio_code = `APCM_CODE_INVALID;
    for (int c = 0; c < `APCM_RATIO_CODES; c++) begin
      if (n == PW'(ratio_val(4'(c))))
        ratio_code = 4'(c);
    end
  endfunction

  // Register file
  logic [7:0] role_r, role_nxt, rate_r, rate_nxt, sts_r, sts_nxt, rd_r, rd_nxt;
  logic       drain_rdy, buf_vld;
  logic [7:0] buf_word;
  logic       master, manual, byp, gate, family;

  assign master = role_r[`APCM_B_ROLE];
  assign manual = role_r[`APCM_B_MANUAL];
  assign byp    = role_r[`APCM_B_PLL_BYP];
  assign gate   = role_r[`APCM_B_GATE];
  assign family = role_r[`APCM_B_FAMILY];
  // Status updates wait out a read so a read never sees a half-new word
  assign drain_rdy = !reg_rd;

  always_comb begin
    role_nxt = role_r;
    rate_nxt = rate_r;
    sts_nxt  = sts_r;
    rd_nxt   = rd_r;
    if (reg_wr && reg_addr == `APCM_OFS_ROLE) role_nxt = reg_wdata;
    if (reg_wr && reg_addr == `APCM_OFS_RATE) rate_nxt = reg_wdata;
    // (RL10) Monitor result lands
    if (buf_vld && drain_rdy) sts_nxt = buf_word;
    if (reg_rd) begin
      unique case (reg_addr)
        `APCM_OFS_ROLE: rd_nxt = role_r;
        `APCM_OFS_RATE: rd_nxt = rate_r;
        `APCM_OFS_STS:  rd_nxt = sts_r;
        default:        rd_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      role_r <= `APCM_RST_ROLE;
      rate_r <= `APCM_RST_RATE;
      // (RL12) Invalid until measured
      sts_r  <= `APCM_RST_STS;
      rd_r   <= 8'h00;
    end else begin
      role_r <= role_nxt;
      rate_r <= rate_nxt;
      sts_r  <= sts_nxt;
      rd_r   <= rd_nxt;
    end
  end
  assign reg_rdata = rd_r;

  // Clock configuration outputs
  logic       pll_nxt, pll_r, ref_frame_nxt, ref_frame_r, pins_nxt, pins_r, oe_nxt, oe_r;
  logic [1:0] root_nxt, root_r;
  always_comb begin
    // (RL2) Auto derives, manual takes custom setting
    // (RL3) Bypass in auto
    pll_nxt = manual ? custom_pll_enable : !byp;
    // (RL14) Slave root clock
    if (!master && !manual && byp)
      root_nxt = slave_root_clock_source ? apcm_pkg::APCM_ROOT_REF : apcm_pkg::APCM_ROOT_BCLK;
    else
      root_nxt = pll_nxt ? apcm_pkg::APCM_ROOT_PLL : apcm_pkg::APCM_ROOT_REF;
    // (RL13) Reference frequency source
    ref_frame_nxt = master && reference_frequency_mode;
    // (RL8) Slave auto follows pins
    pins_nxt = !master && !manual;
    // (RL1) Drive pins only as master
    oe_nxt = !master;
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      pll_r       <= 1'b1;
      root_r      <= apcm_pkg::APCM_ROOT_BCLK;
      ref_frame_r <= 1'b0;
      pins_r      <= 1'b1;
      oe_r        <= 1'b1;
    end else begin
      pll_r       <= pll_nxt;
      root_r      <= root_nxt;
      ref_frame_r <= ref_frame_nxt;
      pins_r      <= pins_nxt;
      oe_r        <= oe_nxt;
    end
  end
  assign pll_enable           = pll_r;
  assign root_clock_select    = root_r;
  assign reference_from_frame = ref_frame_r;
  assign clocks_from_pins     = pins_r;
  // (RL6) Code passed on as stored
  assign reference_frequency_code = role_r[`APCM_F_REF];

  // Master generator: phase accumulator gives exact average bit clock rate up to CLK_HZ/2
  logic [33:0] acc_r, acc_nxt, step;
  logic [31:0] fs;
  logic [11:0] ratio, bcnt_r, bcnt_nxt;
  logic        gen_r, gen_nxt, gfs_r, gfs_nxt, run;
  logic        bo_nxt, bo_r, fo_nxt, fo_r;
  always_comb begin
    // (RL5) Family scales the base rate
    fs = family ? 32'(64'(rate_hz(rate_r[`APCM_F_RATE])) * `APCM_FAM441_NUM
                      / `APCM_FAM441_DEN) : rate_hz(rate_r[`APCM_F_RATE]);
    // (RL9) Programmed ratio
    ratio = ratio_val(rate_r[`APCM_F_RATIO]);
    // (RL7) Reserved rate or ratio stops the generator
    run  = master && fs != 32'd0 && ratio != 12'd0;
    step = 34'(64'(fs) * 64'(ratio) * 64'd2);
    acc_nxt  = acc_r + step;
    gen_nxt  = gen_r;
    bcnt_nxt = bcnt_r;
    gfs_nxt  = gfs_r;
    if (!run) begin
      acc_nxt  = 34'h0;
      gen_nxt  = 1'b0;
      bcnt_nxt = 12'h000;
      gfs_nxt  = 1'b0;
    end else if (acc_nxt >= 34'(CLK_HZ)) begin
      // (RL15) Bit clock edge; frame sync high for the first bit of each frame
      acc_nxt = (step >= 34'(CLK_HZ)) ? 34'h0 : acc_nxt - 34'(CLK_HZ);
      gen_nxt = !gen_r;
      if (gen_r) begin
        bcnt_nxt = (bcnt_r + 12'd1 >= ratio) ? 12'h000 : bcnt_r + 12'd1;
        gfs_nxt  = (bcnt_nxt == 12'h000);
      end
    end
    // (RL4) Gate forces transmitted clocks low
    bo_nxt = gen_nxt && !gate;
    fo_nxt = gfs_nxt && !gate;
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      acc_r  <= 34'h0;
      gen_r  <= 1'b0;
      bcnt_r <= 12'h000;
      gfs_r  <= 1'b0;
      bo_r   <= 1'b0;
      fo_r   <= 1'b0;
    end else begin
      acc_r  <= acc_nxt;
      gen_r  <= gen_nxt;
      bcnt_r <= bcnt_nxt;
      gfs_r  <= gfs_nxt;
      bo_r   <= bo_nxt;
      fo_r   <= fo_nxt;
    end
  end
  assign bclk_out  = bo_r;
  assign frame_sync_out = fo_r;
  // Enables come from a flop so the pins never see decode glitches
  assign bclk_oe_n  = oe_r;
  assign frame_sync_oe_n = oe_r;

  // Clock monitor: frame period in cycles and bit clock rises per frame
  logic          pb_r, pf_r, seen_r, seen_nxt, pend_r, pend_nxt, src_rdy;
  logic [PW-1:0] cyc_r, cyc_nxt, nb_r, nb_nxt;
  logic [7:0]    pw_r, pw_nxt;
  logic          mb, mf;
  // Monitors the pre-gate clock in master mode, the pins in slave mode
  assign mb = master ? gen_r : bclk_in;
  assign mf = master ? gfs_r : frame_sync_in;
  always_comb begin
    cyc_nxt  = (&cyc_r) ? cyc_r : cyc_r + PW'(1);
    nb_nxt   = (mb && !pb_r && !(&nb_r)) ? nb_r + PW'(1) : nb_r;
    seen_nxt = seen_r;
    pend_nxt = pend_r && !src_rdy;
    pw_nxt   = pw_r;
    if (mf && !pf_r) begin
      // (RL11) Ratio and rate coded from one frame
      if (seen_r && !pend_nxt) begin
        pw_nxt   = {rate_code(cyc_r), ratio_code(nb_r)};
        pend_nxt = 1'b1;
      end
      seen_nxt = 1'b1;
      cyc_nxt  = PW'(1);
      nb_nxt   = (mb && !pb_r) ? PW'(1) : PW'(0);
    end else if (cyc_r == PW'(CLK_HZ / `APCM_STALL_DIV) && !pend_nxt) begin
      // Clocks stopped for two slowest frames: report invalid once
      pw_nxt   = `APCM_RST_STS;
      pend_nxt = 1'b1;
      seen_nxt = 1'b0;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      pb_r   <= 1'b0;
      pf_r   <= 1'b0;
      seen_r <= 1'b0;
      pend_r <= 1'b0;
      cyc_r  <= '0;
      nb_r   <= '0;
      pw_r   <= `APCM_RST_STS;
    end else begin
      pb_r   <= mb;
      pf_r   <= mf;
      seen_r <= seen_nxt;
      pend_r <= pend_nxt;
      cyc_r  <= cyc_nxt;
      nb_r   <= nb_nxt;
      pw_r   <= pw_nxt;
    end
  end

  // Two-entry buffer between monitor and status register
  logic [7:0] mem [DEPTH];
  logic [$clog2(DEPTH):0] cnt_r, cnt_nxt;
  logic [$clog2(DEPTH)-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic push, pop;
  assign src_rdy  = cnt_r != ($clog2(DEPTH)+1)'(DEPTH);
  assign buf_vld  = cnt_r != '0;
  assign buf_word = mem[rp_r];
  assign push     = pend_r && src_rdy;
  assign pop      = buf_vld && drain_rdy;
  always_comb begin
    wp_nxt  = push ? wp_r + 1'b1 : wp_r;
    rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + ($clog2(DEPTH)+1)'(push) - ($clog2(DEPTH)+1)'(pop);
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
    if (push) mem[wp_r] <= pw_r;
  end

  a_gate_low: assert property (@(posedge mclk) disable iff (rst) // (RL4)
    gate |=> !bclk_out && !frame_sync_out) else $error("gated clock toggled");
  a_slave_release: assert property (@(posedge mclk) disable iff (rst) // (RL1)
    !master |=> bclk_oe_n && frame_sync_oe_n) else $error("slave drives clock pin");
  a_pll_bypass: assert property (@(posedge mclk) disable iff (rst) // (RL3)
    !manual && byp |=> !pll_enable) else $error("PLL left on in bypass");
  a_pll_auto_on: assert property (@(posedge mclk) disable iff (rst) // (RL2)
    !manual && !byp |=> pll_enable) else $error("auto PLL not running");
  a_root_slave: assert property (@(posedge mclk) disable iff (rst) // (RL14)
    !master && !manual && byp && !slave_root_clock_source
    |=> root_clock_select == apcm_pkg::APCM_ROOT_BCLK) else $error("wrong root clock");
  a_reset_sts: assert property (@(posedge mclk) // (RL12)
    $fell(rst) |-> sts_r == `APCM_RST_STS) else $error("status reset not ones");
  a_pins_follow: assert property (@(posedge mclk) disable iff (rst) // (RL8)
    $changed(role_r) |=> clocks_from_pins == (!master && !manual))
    else $error("pin timing flag stale");
  a_fs_first_bit: assert property (@(posedge mclk) disable iff (rst) // (RL15)
    $rose(gfs_r) |-> $fell(gen_r) && bcnt_r == 12'h000) else $error("frame sync misplaced");
  a_sts_code: assert property (@(posedge mclk) disable iff (rst) // (RL10)
    $changed(sts_r) |-> $past(buf_vld) && $past(drain_rdy)) else $error("status without result");
  a_ratio_code: assert property (@(posedge mclk) disable iff (rst) // (RL11)
    push |-> pw_r[3:0] < 4'(`APCM_RATIO_CODES) || pw_r[3:0] == `APCM_CODE_INVALID)
    else $error("reserved ratio code");
  a_rsvd_stop: assert property (@(posedge mclk) disable iff (rst) // (RL7)
    rate_r[`APCM_F_RATE] >= 4'(`APCM_RATE_CODES) |=> !gen_r) else $error("reserved rate ran");
endmodule // apcm_top
`default_nettype wire

// *** bench/apcm_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module apcm_host_model (
  input  wire logic        mclk,
  input  wire logic        run,
  input  wire logic [7:0]  bit_cyc,
  input  wire logic [11:0] bits,
  output logic             bclk,
  output logic             frame_sync
);
  logic [7:0]  cyc;
  logic [11:0] bit_n;
  initial begin
    bclk = 1'b0;
    frame_sync = 1'b0;
    cyc = 8'h00;
    bit_n = 12'h000;
  end
  // host drives both clocks
  // Clocks stand low between runs; the released pins are pulled down
  always @(posedge mclk) begin
    if (!run) begin
      cyc <= 8'h00;
      bit_n <= 12'h000;
      bclk <= 1'b0;
      frame_sync <= 1'b0;
    end else begin
      bclk <= (cyc < (bit_cyc >> 1));
      frame_sync <= (bit_n == 12'h000);
      if (cyc == bit_cyc - 8'h01) begin
        cyc <= 8'h00;
        bit_n <= (bit_n == bits - 12'h001) ? 12'h000 : bit_n + 12'h001;
      end else begin
        cyc <= cyc + 8'h01;
      end
    end
  end
endmodule // apcm_host_model
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        mclk, rst, reg_wr, reg_rd;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic        bclk_out, bclk_oe_n, frame_sync_out, frame_sync_oe_n, bclk_pin, frame_sync_pin;
  logic        ref_mode, root_src, custom_pll, pll_enable, ref_frame, from_pins;
  logic [1:0]  root_sel;
  logic [2:0]  ref_code;
  logic        host_run, host_bclk, host_frame_sync;
  logic [7:0]  host_cyc;
  logic [11:0] host_bits;
  int          miscompares, n_compared, cycles, rises, r0, fc, nb;
  // Wire level of the shared clock pins
  assign bclk_pin = bclk_oe_n ? host_bclk : bclk_out;
  assign frame_sync_pin = frame_sync_oe_n ? host_frame_sync : frame_sync_out;
  apcm_top apcm_top_inst (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bclk_in(bclk_pin),
    .bclk_out(bclk_out), .bclk_oe_n(bclk_oe_n), .frame_sync_in(frame_sync_pin), .frame_sync_out(frame_sync_out),
    .frame_sync_oe_n(frame_sync_oe_n), .reference_frequency_mode(ref_mode),
    .slave_root_clock_source(root_src), .custom_pll_enable(custom_pll),
    .pll_enable(pll_enable), .root_clock_select(root_sel),
    .reference_frequency_code(ref_code), .reference_from_frame(ref_frame),
    .clocks_from_pins(from_pins));
  apcm_host_model apcm_host_model_inst (.mclk(mclk), .run(host_run), .bit_cyc(host_cyc),
    .bits(host_bits), .bclk(host_bclk), .frame_sync(host_frame_sync));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge bclk_out) rises++;
  task automatic tally_and_finish();
    if (miscompares == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Run ceiling well above the roughly 39000 cycles the sequence needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 90000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    @(negedge mclk);
    check(16'(reg_rdata), 16'(exp));
  endtask
  // First frame after a change may be short, so the second one is kept
  task automatic measure();
    int t0;
    @(posedge frame_sync_out);
    @(posedge frame_sync_out);
    #1;
    r0 = rises;
    t0 = int'($time);
    @(posedge frame_sync_out);
    #1;
    fc = (int'($time) - t0) / 25;
    nb = rises - r0;
  endtask
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, ref_mode, root_src, custom_pll, host_run} = 6'h00;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    host_cyc = 8'h0d;
    host_bits = 12'h040;
    {miscompares, n_compared, cycles, rises} = {32'd0, 32'd0, 32'd0, 32'd0};
    idle(5);
    rst = 1'b0;
    rd_chk(8'h15, 8'hff);
    rd_chk(8'h13, 8'h02);
    rd_chk(8'h14, 8'h48);
    rd_chk(8'h20, 8'h00);
    check(16'(bclk_oe_n), 16'h0001);
    check(16'(from_pins), 16'h0001);
    check(16'(pll_enable), 16'h0001);
    check(16'(ref_code), 16'h0002);
    wr(8'h15, 8'h00);
    rd_chk(8'h15, 8'hff);
    wr(8'h14, 8'h8c);
    rd_chk(8'h14, 8'h8c);
    host_run = 1'b1;
    idle(3000);
    rd_chk(8'h15, 8'h44);
    host_run = 1'b0;
    idle(10600);
    rd_chk(8'h15, 8'hff);
    host_cyc = 8'h9c;
    host_bits = 12'h020;
    host_run = 1'b1;
    idle(16000);
    rd_chk(8'h15, 8'h02);
    host_run = 1'b0;
    wr(8'h13, 8'h22);
    idle(3);
    check(16'(pll_enable), 16'h0000);
    check(16'(root_sel), 16'h0001);
    root_src = 1'b1;
    idle(3);
    check(16'(root_sel), 16'h0002);
    custom_pll = 1'b1;
    wr(8'h13, 8'h42);
    idle(3);
    check(16'(pll_enable), 16'h0001);
    check(16'(from_pins), 16'h0000);
    custom_pll = 1'b0;
    idle(3);
    check(16'(pll_enable), 16'h0000);
    wr(8'h14, 8'h44);
    wr(8'h13, 8'h82);
    idle(2);
    check(16'({bclk_oe_n, frame_sync_oe_n}), 16'h0000);
    measure();
    check(16'(fc >= 832 && fc <= 834), 16'h0001);
    check(16'(nb), 16'h0040);
    rd_chk(8'h15, 8'h44);
    wr(8'h13, 8'h8a);
    measure();
    check(16'(fc >= 906 && fc <= 908), 16'h0001);
    ref_mode = 1'b1;
    wr(8'h13, 8'h8d);
    idle(3);
    check(16'(ref_code), 16'h0005);
    check(16'(ref_frame), 16'h0001);
    ref_mode = 1'b0;
    idle(3);
    check(16'(ref_frame), 16'h0000);
    wr(8'h13, 8'h9a);
    idle(20);
    r0 = rises;
    idle(2000);
    check(16'(rises - r0), 16'h0000);
    check(16'(frame_sync_out), 16'h0000);
    wr(8'h13, 8'h8a);
    wr(8'h14, 8'h94);
    idle(20);
    r0 = rises;
    idle(2000);
    check(16'(rises - r0), 16'h0000);
    wr(8'h13, 8'h02);
    idle(3);
    check(16'({bclk_oe_n, frame_sync_oe_n}), 16'h0003);
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
